// file: hdl/alb_core.sv
// alb_core: logic, subtract and indirect branch slice behind an apb slave
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module alb_core import alb_pkg::*; #(
  parameter int STACK_DEPTH = 16
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  input  wire alb_apb_req_s i_apb,
  output alb_apb_rsp_s      o_apb,
  output logic [PC_W-1:0]   o_pc,
  output alb_flags_s        o_flags,
  output logic              o_busy
);

  localparam int SP_W = $clog2(STACK_DEPTH + 1);
  localparam int AW   = $clog2(STACK_DEPTH);
  localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);
  localparam logic [SP_W-1:0] SP_ONE  = SP_W'(1);

  typedef struct packed {
    alb_state_e        st;
    alb_op_e           op;
    logic [DATA_W-1:0] dest;
    logic [DATA_W-1:0] imm;
    alb_flags_s        flg;
    logic [PTR_W-1:0]  ptr;
    logic [PC_W-1:0]   pc;
    logic [SP_W-1:0]   sp;
    logic              ovf;
    logic              unf;
    logic              bad;
    logic [APB_DW-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              busy;
  } alb_core_s;

  alb_core_s         core_reg;
  alb_core_s         core_next;
  logic              mem_we;
  logic [AW-1:0]     mem_waddr;
  logic [PC_W-1:0]   mem_wdata;
  logic [AW-1:0]     mem_raddr;
  logic [PC_W-1:0]   mem_rdata;
  logic              apb_access;
  logic              addr_hit;
  logic [APB_DW-1:0] read_value;
  logic [DATA_W-1:0] res;
  logic [DATA_W:0]   diff;

  // flags of a logical result: overflow cleared, sign equals negative
  function automatic alb_flags_s logic_flags(input logic [DATA_W-1:0] r,
                                             input logic carry);
    alb_flags_s f;
    f.c = carry;
    f.z = (r == '0);
    f.n = r[DATA_W-1];
    f.v = 1'b0;
    f.s = f.n ^ f.v;
    return f;
  endfunction : logic_flags

  // true when an address selects one of the mapped registers
  function automatic logic is_mapped(input logic [APB_AW-1:0] a);
    return (a == OFS_CMD) || (a == OFS_DEST) || (a == OFS_IMM) ||
           (a == OFS_FLAGS) || (a == OFS_PTR) || (a == OFS_PC) ||
           (a == OFS_STAT);
  endfunction : is_mapped

  // return address store, read port always points at the top entry
  alb_stack_mem #(
    .WIDTH (PC_W),
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (mem_wdata),
    .i_raddr (mem_raddr),
    .o_rdata (mem_rdata)
  );

  assign apb_access = i_apb.psel & i_apb.penable;
  assign addr_hit   = is_mapped(i_apb.paddr);
  assign mem_raddr  = AW'(core_reg.sp - SP_ONE);

  // read mux; unmapped addresses read as zero
  always_comb begin
    read_value = '0;
    if (i_apb.paddr == OFS_CMD) begin
      read_value[3:0] = core_reg.op;
    end else if (i_apb.paddr == OFS_DEST) begin
      read_value[DATA_W-1:0] = core_reg.dest;
    end else if (i_apb.paddr == OFS_IMM) begin
      read_value[DATA_W-1:0] = core_reg.imm;
    end else if (i_apb.paddr == OFS_FLAGS) begin
      read_value[FLAG_S_BIT:FLAG_C_BIT] = core_reg.flg;
    end else if (i_apb.paddr == OFS_PTR) begin
      read_value[PTR_W-1:0] = core_reg.ptr;
    end else if (i_apb.paddr == OFS_PC) begin
      read_value[PC_W-1:0] = core_reg.pc;
    end else if (i_apb.paddr == OFS_STAT) begin
      read_value[STAT_BUSY_BIT] = (core_reg.st != ST_IDLE);
      read_value[STAT_OVF_BIT]  = core_reg.ovf;
      read_value[STAT_UNF_BIT]  = core_reg.unf;
      read_value[STAT_BAD_BIT]  = core_reg.bad;
      read_value[STAT_SP_LSB +: SP_W] = core_reg.sp;
    end
  end

  // bus slave and sequencer, one cycle per operation except return
  always_comb begin
    core_next = core_reg;
    mem_we    = 1'b0;
    mem_waddr = AW'(core_reg.sp);
    mem_wdata = PC_W'(core_reg.pc + 1'b1);
    res       = core_reg.dest;
    diff      = '0;

    // answer only while idle, so software never sees a half-done op
    if (apb_access && !core_reg.pready && core_reg.st == ST_IDLE) begin
      core_next.pready  = 1'b1;
      core_next.pslverr = !addr_hit;
      core_next.prdata  = i_apb.pwrite ? '0 : read_value;
    end else if (apb_access && core_reg.pready) begin
      // the write lands on the edge where the master sees pready
      core_next.pready  = 1'b0;
      core_next.pslverr = 1'b0;
      if (i_apb.pwrite && addr_hit) begin
        if (i_apb.paddr == OFS_CMD) begin
          core_next.op = alb_op_e'(i_apb.pwdata[3:0]);
          core_next.st = ST_EXEC;
        end else if (i_apb.paddr == OFS_DEST) begin
          core_next.dest = i_apb.pwdata[DATA_W-1:0];
        end else if (i_apb.paddr == OFS_IMM) begin
          core_next.imm = i_apb.pwdata[DATA_W-1:0];
        end else if (i_apb.paddr == OFS_FLAGS) begin
          core_next.flg = i_apb.pwdata[FLAG_S_BIT:FLAG_C_BIT];
        end else if (i_apb.paddr == OFS_PTR) begin
          core_next.ptr = i_apb.pwdata[PTR_W-1:0];
        end else if (i_apb.paddr == OFS_PC) begin
          core_next.pc = i_apb.pwdata[PC_W-1:0];
        end else if (i_apb.paddr == OFS_STAT) begin
          // write one to clear; events come later in the code and win
          if (i_apb.pwdata[STAT_OVF_BIT]) begin
            core_next.ovf = 1'b0;
          end
          if (i_apb.pwdata[STAT_UNF_BIT]) begin
            core_next.unf = 1'b0;
          end
          if (i_apb.pwdata[STAT_BAD_BIT]) begin
            core_next.bad = 1'b0;
          end
        end
      end
    end

    case (core_reg.st)
      ST_EXEC: begin
        core_next.st = ST_IDLE;
        case (core_reg.op)
          OP_SBCI: begin
            // nine bit difference, the top bit is the borrow out
            diff = {1'b0, core_reg.dest} - {1'b0, core_reg.imm}
                   - {{DATA_W{1'b0}}, core_reg.flg.c};
            res = diff[DATA_W-1:0];
            core_next.dest  = res;
            core_next.flg.c = diff[DATA_W];
            core_next.flg.z = (res == '0);
            core_next.flg.n = res[DATA_W-1];
            // overflow only feeds sign here; stored overflow is kept
            core_next.flg.s = res[DATA_W-1] ^
              ((core_reg.dest[DATA_W-1] & ~core_reg.imm[DATA_W-1] &
                ~res[DATA_W-1]) |
               (~core_reg.dest[DATA_W-1] & core_reg.imm[DATA_W-1] &
                res[DATA_W-1]));
          end
          OP_ORI: begin
            res = core_reg.dest | core_reg.imm;
            core_next.dest = res;
            core_next.flg  = logic_flags(res, core_reg.flg.c);
          end
          OP_AND_IMMEDIATE_OP: begin
            res = core_reg.dest & core_reg.imm;
            core_next.dest  = res;
            // overflow is not in this op's flag set, so it is kept
            core_next.flg.z = (res == '0);
            core_next.flg.n = res[DATA_W-1];
            core_next.flg.s = res[DATA_W-1] ^ core_reg.flg.v;
          end
          OP_SET_MASK: begin
            res = core_reg.dest | core_reg.imm;
            core_next.dest = res;
            core_next.flg  = logic_flags(res, core_reg.flg.c);
          end
          OP_CLR_MASK: begin
            res = core_reg.dest & ~core_reg.imm;
            core_next.dest = res;
            core_next.flg  = logic_flags(res, core_reg.flg.c);
          end
          OP_ZN_CHECK: begin
            res = core_reg.dest & core_reg.dest;
            core_next.flg = logic_flags(res, core_reg.flg.c);
          end
          OP_INVERT: begin
            res = ~core_reg.dest;
            core_next.dest = res;
            core_next.flg  = logic_flags(res, 1'b1);
          end
          OP_NEGATE: begin
            res = DATA_W'(8'h00 - core_reg.dest);
            core_next.dest  = res;
            core_next.flg.c = (res != '0);
            core_next.flg.z = (res == '0);
            core_next.flg.n = res[DATA_W-1];
            core_next.flg.v = (res == NEG_OVF_VAL);
            core_next.flg.s = res[DATA_W-1] ^ (res == NEG_OVF_VAL);
          end
          OP_PTR_JUMP: begin
            core_next.pc = {PC_HI_CLR, core_reg.ptr};
          end
          OP_PTR_CALL: begin
            // a full stack loses the return address but still branches
            if (core_reg.sp == SP_FULL) begin
              core_next.ovf = 1'b1;
            end else begin
              mem_we       = 1'b1;
              core_next.sp = core_reg.sp + SP_ONE;
            end
            core_next.pc = {PC_HI_CLR, core_reg.ptr};
          end
          OP_SUB_EXIT: begin
            // the top entry is read this cycle and lands in pop
            if (core_reg.sp == '0) begin
              core_next.unf = 1'b1;
            end else begin
              core_next.st = ST_POP;
            end
          end
          default: begin
            core_next.bad = 1'b1;
          end
        endcase
      end
      ST_POP: begin
        core_next.pc = mem_rdata;
        core_next.sp = core_reg.sp - SP_ONE;
        core_next.st = ST_IDLE;
      end
      ST_IDLE: begin
        // keep the state that a command write above may have set
      end
      default: begin
        core_next.st = ST_IDLE;
      end
    endcase

    // busy is registered so the output comes straight from a flop
    core_next.busy = (core_next.st != ST_IDLE);
  end

  // single state register for the whole block apart from the stack store, which keeps its own
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      core_reg.st      <= ST_IDLE;
      core_reg.op      <= OP_NONE;
      core_reg.dest    <= DEST_RST;
      core_reg.imm     <= IMM_RST;
      core_reg.flg     <= FLAGS_RST;
      core_reg.ptr     <= PTR_RST;
      core_reg.pc      <= PC_RST;
      core_reg.sp      <= '0;
      core_reg.ovf     <= 1'b0;
      core_reg.unf     <= 1'b0;
      core_reg.bad     <= 1'b0;
      core_reg.prdata  <= '0;
      core_reg.pready  <= 1'b0;
      core_reg.pslverr <= 1'b0;
      core_reg.busy    <= 1'b0;
    end else begin
      core_reg <= core_next;
    end
  end

  // outputs are plain register fields
  assign o_apb.prdata  = core_reg.prdata;
  assign o_apb.pready  = core_reg.pready;
  assign o_apb.pslverr = core_reg.pslverr;
  assign o_pc          = core_reg.pc;
  assign o_flags       = core_reg.flg;
  assign o_busy        = core_reg.busy;

endmodule : alb_core

// file: hdl/alb_pkg.sv
// alb_pkg: shared constants, register map and types of the alu slice
package alb_pkg;

  // widths of the datapath
  localparam int DATA_W = 8;
  localparam int PTR_W  = 16;
  localparam int PC_W   = 22;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // register byte offsets
  localparam logic [APB_AW-1:0] OFS_CMD   = 8'h00;
  localparam logic [APB_AW-1:0] OFS_DEST  = 8'h04;
  localparam logic [APB_AW-1:0] OFS_IMM   = 8'h08;
  localparam logic [APB_AW-1:0] OFS_FLAGS = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_PTR   = 8'h10;
  localparam logic [APB_AW-1:0] OFS_PC    = 8'h14;
  localparam logic [APB_AW-1:0] OFS_STAT  = 8'h18;

  // field positions in the status register
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_OVF_BIT  = 1;
  localparam int STAT_UNF_BIT  = 2;
  localparam int STAT_BAD_BIT  = 3;
  localparam int STAT_SP_LSB   = 8;

  // field positions in the flags register
  localparam int FLAG_C_BIT = 0;
  localparam int FLAG_Z_BIT = 1;
  localparam int FLAG_N_BIT = 2;
  localparam int FLAG_V_BIT = 3;
  localparam int FLAG_S_BIT = 4;

  // values after reset
  localparam logic [DATA_W-1:0] DEST_RST  = 8'h00;
  localparam logic [DATA_W-1:0] IMM_RST   = 8'h00;
  localparam logic [PTR_W-1:0]  PTR_RST   = 16'h0000;
  localparam logic [PC_W-1:0]   PC_RST    = 22'h000000;
  localparam logic [4:0]        FLAGS_RST = 5'h00;

  // special operand values
  localparam logic [DATA_W-1:0] NEG_OVF_VAL = 8'h80;
  localparam logic [PC_W-PTR_W-1:0] PC_HI_CLR = 6'h00;

  // operations started by a write to the command register
  typedef enum logic [3:0] {
    OP_NONE      = 4'h0,
    OP_SBCI      = 4'h1, // subtract_imm_with_borrow_op
    OP_ORI       = 4'h2, // or_immediate_op
    OP_AND_IMMEDIATE_OP      = 4'h3, // and_immediate_op
    OP_SET_MASK  = 4'h4, // set_mask_bits_op
    OP_CLR_MASK  = 4'h5, // clear_mask_bits_op
    OP_ZN_CHECK  = 4'h6, // zero_negative_check_op
    OP_INVERT    = 4'h7, // invert_op
    OP_NEGATE    = 4'h8, // negate_op
    OP_PTR_JUMP  = 4'h9, // pointer_jump_op
    OP_PTR_CALL  = 4'ha, // pointer_call_op
    OP_SUB_EXIT  = 4'hb  // subroutine_exit_op
  } alb_op_e;

  // sequencer states, gray along idle -> exec -> pop
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_POP  = 2'b11
  } alb_state_e;

  // status flags, bit 0 is carry
  typedef struct packed {
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } alb_flags_s;

  // apb request from the master
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
  } alb_apb_req_s;

  // apb answer from the slave
  typedef struct packed {
    logic [APB_DW-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } alb_apb_rsp_s;

endpackage : alb_pkg

// file: hdl/alb_stack_mem.sv
// alb_stack_mem: return address store with registered read data
`timescale 1ns/1ps
module alb_stack_mem #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 16
) (
  input  wire logic                     i_clock,
  input  wire logic                     i_rst,
  input  wire logic                     i_we,
  input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input  wire logic [WIDTH-1:0]         i_wdata,
  input  wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic      [WIDTH-1:0]         o_rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            rdata;
  } alb_mem_s;

  alb_mem_s mem_reg;
  alb_mem_s mem_next;

  // read is registered so a pop takes one extra cycle
  always_comb begin
    mem_next       = mem_reg;
    mem_next.rdata = mem_reg.mem[i_raddr];
    if (i_we) begin
      mem_next.mem[i_waddr] = i_wdata;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      mem_reg <= '0;
    end else begin
      mem_reg <= mem_next;
    end
  end

  assign o_rdata = mem_reg.rdata;

endmodule : alb_stack_mem

// file: sim/alb_core_chk.sv
// alb_core_chk: bus and result checks at the ports of the alu slice
`timescale 1ns/1ps
module alb_core_chk import alb_pkg::*; (
  input wire logic            i_clock,
  input wire logic            i_rst,
  input wire alb_apb_req_s    i_apb,
  input wire alb_apb_rsp_s    o_apb,
  input wire logic [PC_W-1:0] o_pc,
  input wire alb_flags_s      o_flags,
  input wire logic            o_busy
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // a command write completing at this edge
  logic cmd_wr;
  assign cmd_wr = i_apb.psel && i_apb.penable && o_apb.pready
                  && i_apb.pwrite && i_apb.paddr == OFS_CMD;

  ready_pulse_a: assert property (o_apb.pready |=> !o_apb.pready)
    else $error("ready held longer than one cycle");
  ready_access_a: assert property (o_apb.pready |-> i_apb.psel
    && i_apb.penable && $past(i_apb.penable))
    else $error("ready outside a second access cycle");
  err_ready_a: assert property (o_apb.pslverr |-> o_apb.pready)
    else $error("error flag without ready");
  busy_wait_a: assert property (o_busy |-> !o_apb.pready)
    else $error("access answered while busy");
  wr_data_a: assert property (o_apb.pready && i_apb.pwrite
    |-> o_apb.prdata == 32'h0) else $error("write answer not zero");
  op_short_a: assert property ($rose(o_busy) |-> ##[1:2] !o_busy)
    else $error("operation ran too long");
  branch_flags_a: assert property (cmd_wr && i_apb.pwdata[3:0] inside
    {4'h9, 4'ha, 4'hb} |=> $stable(o_flags)[*2])
    else $error("branch touched the flags");
  ptr_high_a: assert property (cmd_wr && i_apb.pwdata[3:0] inside
    {4'h9, 4'ha} |-> ##2 o_pc[21:16] == 6'h00)
    else $error("upper pc bits not cleared");
  invert_carry_a: assert property (cmd_wr
    && i_apb.pwdata[3:0] == 4'h7 |-> ##2 o_flags.c)
    else $error("invert left carry clear");
endmodule : alb_core_chk

bind alb_core alb_core_chk alb_core_chk_i (.i_clock(i_clock), .i_rst(i_rst),
  .i_apb(i_apb), .o_apb(o_apb), .o_pc(o_pc), .o_flags(o_flags),
  .o_busy(o_busy));

// file: sim/alb_core_tb.sv
// alb_core_tb: register level regression of the alu slice over apb
`timescale 1ns/1ps
module alb_core_tb import alb_pkg::*; ;
  logic            i_clock = 1'b0;
  logic            i_rst   = 1'b1;
  alb_apb_req_s    apb_req = '0;
  alb_apb_rsp_s    apb_rsp;
  logic [PC_W-1:0] pc;
  alb_flags_s      flags;
  logic            busy;
  int              errors = 0;
  int              samples_checked = 0;
  int              cycles = 0;
  logic [31:0]     rd;
  logic            err;
  logic [12:0]     exp;
  logic [7:0]      dv[3] = '{8'h80, 8'h00, 8'h5a};
  logic [7:0]      kv[3] = '{8'h01, 8'h00, 8'hff};
  logic [4:0]      fv[3] = '{5'h09, 5'h00, 5'h1f};

  // small stack so overflow is reached in a few calls
  alb_core #(.STACK_DEPTH(4)) alb_core_i (.i_clock(i_clock), .i_rst(i_rst),
    .i_apb(apb_req), .o_apb(apb_rsp), .o_pc(pc), .o_flags(flags),
    .o_busy(busy));

  always #25 i_clock = ~i_clock;

  // hang guard, far above the 154 transfers run here
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  // one apb transfer; request held until ready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge i_clock);
    apb_req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
    @(posedge i_clock);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge i_clock);
      // only the hang guard ends a wait that never sees ready
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : xfer

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc

  task automatic cmd(input logic [3:0] op);
    xfer(1'b1, OFS_CMD, {28'h0, op});
  endtask : cmd

  // expected {flags, result}; flags the op leaves alone are kept
  function automatic logic [12:0] model(input logic [3:0] op,
    input logic [7:0] d, input logic [7:0] k, input logic [4:0] f);
    logic [8:0] t;
    logic [7:0] r;
    logic       c, z, n, v, s;
    {s, v, n, z, c} = f;
    t = 9'h000;
    case (op)
      4'h1: t = {1'b0, d} - {1'b0, k} - {8'h00, f[0]};
      4'h2, 4'h4: t[7:0] = d | k;
      4'h3: t[7:0] = d & k;
      4'h5: t[7:0] = d & ~k;
      4'h6: t[7:0] = d;
      4'h7: t[7:0] = ~d;
      default: t[7:0] = 8'h00 - d;
    endcase
    r = t[7:0];
    z = (r == 8'h00);
    n = r[7];
    case (op)
      4'h1: begin
        c = t[8];
        s = n ^ ((d[7] & ~k[7] & ~r[7]) | (~d[7] & k[7] & r[7]));
      end
      4'h3: s = n ^ v;
      4'h8: begin
        c = (r != 8'h00);
        v = (r == 8'h80);
        s = n ^ v;
      end
      default: begin
        v = 1'b0;
        s = n;
        c = c | (op == 4'h7);
      end
    endcase
    return {s, v, n, z, c, r};
  endfunction : model

  initial begin
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    // every register reads zero after reset
    for (int a = 0; a <= 24; a += 4) rdc(a[7:0], 32'h0);
    // each arithmetic and logic code over boundary operands
    for (int op = 1; op <= 8; op++) begin
      for (int i = 0; i < 3; i++) begin
        exp = model(op[3:0], dv[i], kv[i], fv[i]);
        xfer(1'b1, OFS_DEST, {24'h0, dv[i]});
        xfer(1'b1, OFS_IMM, {24'h0, kv[i]});
        xfer(1'b1, OFS_FLAGS, {27'h0, fv[i]});
        cmd(op[3:0]);
        rdc(OFS_DEST, {24'h0, exp[7:0]});
        chk({27'h0, flags}, {27'h0, exp[12:8]});
      end
    end
    // jump drops the upper pc bits and keeps flags
    xfer(1'b1, OFS_FLAGS, 32'h15);
    xfer(1'b1, OFS_PC, 32'h3f0000);
    xfer(1'b1, OFS_PTR, 32'hbeef);
    cmd(4'h9);
    rdc(OFS_PC, 32'h00beef);
    chk({27'h0, flags}, 32'h15);
    chk({10'h0, pc}, 32'h00beef);
    // five calls into a four deep stack, then five returns
    xfer(1'b1, OFS_PC, 32'h2a0010);
    xfer(1'b1, OFS_PTR, 32'h1234);
    repeat (5) cmd(4'ha);
    rdc(OFS_PC, 32'h001234);
    chk({10'h0, pc}, 32'h001234);
    rdc(OFS_STAT, 32'h0402);
    xfer(1'b1, OFS_STAT, 32'h0e);
    repeat (4) cmd(4'hb);
    rdc(OFS_PC, 32'h2a0011);
    chk({10'h0, pc}, 32'h2a0011);
    cmd(4'hb);
    rdc(OFS_STAT, 32'h0004);
    rdc(OFS_PC, 32'h2a0011);
    rdc(OFS_FLAGS, 32'h15);
    // unknown code (underflow still sticky) and an unmapped word
    cmd(4'hc);
    rdc(OFS_STAT, 32'h000c);
    xfer(1'b0, 8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    complete_run();
  end
endmodule : alb_core_tb
